//--- rtl/tom_defs.svh
// Purpose: Constants for the dual channel torque-off monitor
// Assumes: 25 MHz system clock
// Notes:   Times in ms, counts derived from the clock rate
`ifndef TOM_DEFS_SVH
`define TOM_DEFS_SVH
`define TOM_CLK_KHZ          25000
`define TOM_MISMATCH_MS      1000
`define TOM_MISMATCH_CYC     (`TOM_MISMATCH_MS * `TOM_CLK_KHZ)
`define TOM_SHUTOFF_MAX_MS   1600
`define TOM_FAULT_MISMATCH   12'h3c0
`define TOM_FAULT_NO_TRAVEL  12'h216
`define TOM_FAULT_NONE       12'h000
`define TOM_WAIT_MS_DEFAULT  16'h03e8
`endif

//--- rtl/tom_monitor.sv
// Purpose: Compare two torque-enable channels, gate the power stage
// Assumes: srst is the power-on reset; only it clears a latched fault
// Notes:   Wait times are parameters so simulation can shorten them
`include "tom_defs.svh"

module tom_monitor #(
  parameter int unsigned MISMATCH_CYC = `TOM_MISMATCH_CYC,
  parameter int unsigned CYC_PER_MS   = `TOM_CLK_KHZ
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        torque_enable_chan_a,
  input  wire logic        torque_enable_chan_b,
  input  wire logic        travel_cmd,
  input  wire logic [15:0] travel_signal_wait_time,
  output logic             chan_a_active,
  output logic             chan_b_active,
  output logic             channel_check_indicator,
  output logic             gate_enable,
  output logic             torque_off_status_output,
  output logic             mismatch_fault,
  output logic             no_travel_fault,
  output tom_pkg::tom_code_t fault_code
);
  import tom_pkg::*;

  logic       a_sync;
  logic       b_sync;
  logic       travel_sync;
  tom_state_e state_reg;
  logic [31:0] skew_cnt_reg;
  logic [31:0] ms_cnt_reg;
  logic [15:0] wait_ms_reg;
  logic        latched;

  tom_sync u_sync_a (
    .clock (clock),
    .srst  (srst),
    .din   (torque_enable_chan_a),
    .dout  (a_sync)
  );
  tom_sync u_sync_b (
    .clock (clock),
    .srst  (srst),
    .din   (torque_enable_chan_b),
    .dout  (b_sync)
  );
  tom_sync u_sync_t (
    .clock (clock),
    .srst  (srst),
    .din   (travel_cmd),
    .dout  (travel_sync)
  );

  assign latched = (state_reg == TOM_FAULT);

  // Mismatch timer; one-second figure is well inside the 1600 ms bound
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg    <= TOM_IDLE;
      skew_cnt_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        TOM_IDLE: begin
          skew_cnt_reg <= 32'h0000_0000;
          if (a_sync != b_sync) begin
            state_reg <= TOM_SKEW;
          end
        end
        TOM_SKEW: begin
          if (a_sync == b_sync) begin
            state_reg    <= TOM_IDLE;
            skew_cnt_reg <= 32'h0000_0000;
          end else if (skew_cnt_reg >= MISMATCH_CYC - 2) begin
            state_reg <= TOM_FAULT;
          end else begin
            skew_cnt_reg <= skew_cnt_reg + 32'h0000_0001;
          end
        end
        TOM_FAULT: state_reg <= TOM_FAULT;
        default:   state_reg <= TOM_FAULT;
      endcase
    end
  end

  // Both-active-without-travel wait, counted in whole milliseconds
  // Not latched: the fault drops once travel or a channel returns
  always_ff @(posedge clock) begin
    if (srst) begin
      ms_cnt_reg      <= 32'h0000_0000;
      wait_ms_reg     <= 16'h0000;
      no_travel_fault <= 1'b0;
    end else if (a_sync && b_sync && !travel_sync && !no_travel_fault) begin
      if (ms_cnt_reg >= CYC_PER_MS - 1) begin
        ms_cnt_reg <= 32'h0000_0000;
        if (wait_ms_reg >= travel_signal_wait_time) begin
          no_travel_fault <= 1'b1;
        end else begin
          wait_ms_reg <= wait_ms_reg + 16'h0001;
        end
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
      end
    end else if (!(a_sync && b_sync && !travel_sync)) begin
      ms_cnt_reg      <= 32'h0000_0000;
      wait_ms_reg     <= 16'h0000;
      no_travel_fault <= 1'b0;
    end
  end

  // Outputs all registered; a latched mismatch forces the channel, check and gate outputs off
  always_ff @(posedge clock) begin
    if (srst) begin
      chan_a_active            <= 1'b0;
      chan_b_active            <= 1'b0;
      channel_check_indicator  <= 1'b1;
      gate_enable              <= 1'b0;
      torque_off_status_output <= 1'b1;
      mismatch_fault           <= 1'b0;
      fault_code               <= `TOM_FAULT_NONE;
    end else begin
      chan_a_active <= a_sync && !latched;
      chan_b_active <= b_sync && !latched;
      channel_check_indicator <= !latched;
      gate_enable <= a_sync && b_sync && !latched;
      torque_off_status_output <= !(a_sync && b_sync && !latched);
      mismatch_fault <= latched;
      if (latched) begin
        fault_code <= `TOM_FAULT_MISMATCH;
      end else if (no_travel_fault) begin
        fault_code <= `TOM_FAULT_NO_TRAVEL;
      end else begin
        fault_code <= `TOM_FAULT_NONE;
      end
    end
  end

  // Independent count of unlatched disagreement, so the shut-off bound
  // is checked without trusting the state machine's own counter
  logic [31:0] chk_skew_cnt_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      chk_skew_cnt_reg <= 32'h0000_0000;
    end else if ((a_sync != b_sync) && !latched) begin
      chk_skew_cnt_reg <= chk_skew_cnt_reg + 32'h0000_0001;
    end else begin
      chk_skew_cnt_reg <= 32'h0000_0000;
    end
  end

  // Expiry: last tolerated cycle of skew, then the latch, then outputs
  sequence s_skew_last;
    (chk_skew_cnt_reg == MISMATCH_CYC - 1) && (a_sync != b_sync)
      && !latched;
  endsequence

  sequence s_forced_off;
    mismatch_fault && !gate_enable && !channel_check_indicator
      && fault_code == `TOM_FAULT_MISMATCH;
  endsequence

  a_gate_needs_both: assert property (@(posedge clock) disable iff (srst)
    gate_enable |-> $past(a_sync) && $past(b_sync))
    else $error("gate enabled without both channels");

  a_fault_sticks: assert property (@(posedge clock) disable iff (srst)
    mismatch_fault |=> mismatch_fault)
    else $error("mismatch fault cleared without reset");

  a_fault_forces_off: assert property (@(posedge clock) disable iff (srst)
    mismatch_fault |-> !chan_a_active && !chan_b_active
      && !channel_check_indicator && !gate_enable)
    else $error("channels not forced off on fault");

  a_fault_code: assert property (@(posedge clock) disable iff (srst)
    mismatch_fault |-> fault_code == `TOM_FAULT_MISMATCH)
    else $error("wrong code on mismatch");

  a_skew_restart: assert property (@(posedge clock) disable iff (srst)
    (state_reg == TOM_SKEW) && (a_sync == b_sync) |=>
      state_reg == TOM_IDLE && skew_cnt_reg == 0)
    else $error("skew timer not restarted");

  a_skew_bound: assert property (@(posedge clock) disable iff (srst)
    chk_skew_cnt_reg <= MISMATCH_CYC)
    else $error("mismatch timer overran");

  a_expiry_latches: assert property (@(posedge clock) disable iff (srst)
    s_skew_last |=> latched ##1 s_forced_off)
    else $error("expired mismatch timer not latched");

  a_status_mirror: assert property (@(posedge clock) disable iff (srst)
    torque_off_status_output == !(chan_a_active && chan_b_active))
    else $error("status output disagrees with gating");

  a_no_travel_code: assert property (@(posedge clock) disable iff (srst)
    no_travel_fault && !latched |=>
      fault_code == `TOM_FAULT_NO_TRAVEL)
    else $error("travel-missing code absent");

  a_idle_healthy: assert property (@(posedge clock) disable iff (srst)
    !latched && !mismatch_fault |=> channel_check_indicator)
    else $error("check indicator unhealthy without fault");

  a_reset_clears: assert property (@(posedge clock)
    srst |=> !mismatch_fault && !gate_enable && channel_check_indicator
      && torque_off_status_output && fault_code == `TOM_FAULT_NONE)
    else $error("reset left a fault or output standing");

  a_no_travel_clears: assert property (@(posedge clock) disable iff (srst)
    !(a_sync && b_sync && !travel_sync) |=> !no_travel_fault)
    else $error("travel-missing fault outlived its cause");
endmodule // tom_monitor

//--- rtl/tom_pkg.sv
// Purpose: Types for the torque-off monitor
// Assumes: Nothing
// Notes:   Constants live in tom_defs.svh
package tom_pkg;
  typedef logic [11:0] tom_code_t;
  typedef enum logic [1:0] {
    TOM_IDLE  = 2'b00,
    TOM_SKEW  = 2'b01,
    TOM_FAULT = 2'b11
  } tom_state_e;
endpackage

//--- rtl/tom_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input asynchronous to clock
// Notes:   Output changes once stages two and three agree
module tom_sync (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // tom_sync

//--- test/testbench.sv
// Purpose: Self-checking bench for the torque-off monitor
// Assumes: Mismatch shortened to 20 cycles, 4 cycles per ms
// Notes:   Status packed as a, b, check, gate, off, mismatch, no-travel
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tom_pkg::*;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        req = 1'b0;
  logic        br_a = 1'b0;
  logic        br_b = 1'b0;
  logic [15:0] wait_t = 16'h0003;
  logic        ten_a, ten_b, tcmd, a_act, b_act, ok, gate, off, mis, nt;
  tom_code_t   code;
  logic [6:0]  st;
  int          error_cnt = 0;
  int          total_checks = 0;
  assign st = {a_act, b_act, ok, gate, off, mis, nt};
  initial forever #20 clock = ~clock;
  tom_relay_ctrl i_ctrl (.clock(clock), .travel_req(req), .bridge_a(br_a),
    .bridge_b(br_b), .travel_cmd(tcmd), .torque_enable_chan_a(ten_a),
    .torque_enable_chan_b(ten_b));
  tom_monitor #(.MISMATCH_CYC(20), .CYC_PER_MS(4)) i_dut (.clock(clock),
    .srst(srst), .torque_enable_chan_a(ten_a), .torque_enable_chan_b(ten_b),
    .travel_cmd(tcmd), .travel_signal_wait_time(wait_t),
    .chan_a_active(a_act), .chan_b_active(b_act),
    .channel_check_indicator(ok), .gate_enable(gate),
    .torque_off_status_output(off), .mismatch_fault(mis),
    .no_travel_fault(nt), .fault_code(code));
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk_st(input logic [6:0] exp);
    total_checks++;
    if (st !== exp) begin
      error_cnt++;
      $display("BAD %0t status %b want %b", $time, st, exp);
    end
  endtask
  task automatic chk_code(input tom_code_t exp);
    total_checks++;
    if (code !== exp) begin
      error_cnt++;
      $display("BAD %0t code %h want %h", $time, code, exp);
    end
  endtask
  task automatic set(input logic r, input logic a, input logic b);
    @(posedge clock);
    req <= r;
    br_a <= a;
    br_b <= b;
  endtask
  // Sample on the falling edge, clear of the design's own updates
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic rst;
    @(posedge clock);
    srst <= 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    wait_n(6);
  endtask
  task automatic t_travel;
    chk_st(7'b0010100);
    chk_code(12'h000);
    set(1'b1, 1'b0, 1'b0);
    wait_n(8);
    chk_st(7'b1111000);
    set(1'b0, 1'b0, 1'b0);
    wait_n(8);
    chk_st(7'b0010100);
  endtask
  // Two skews each shorter than the limit must not add up to a fault
  task automatic t_skew;
    set(1'b0, 1'b1, 1'b0);
    wait_n(12);
    chk_st(7'b1010100);
    set(1'b0, 1'b0, 1'b0);
    wait_n(6);
    set(1'b0, 1'b1, 1'b0);
    wait_n(12);
    set(1'b0, 1'b0, 1'b0);
    wait_n(8);
    chk_st(7'b0010100);
  endtask
  // 1600 ms scales to 32 cycles, plus relay and input latency
  task automatic t_lone(input logic a, input logic b);
    rst;
    set(1'b0, a, b);
    wait_n(20);
    chk_st({a, b, 5'b10100});
    wait_n(18);
    chk_st(7'b0000110);
    chk_code(12'h3c0);
    set(1'b1, 1'b0, 1'b0);
    wait_n(10);
    chk_st(7'b0000110);
    set(1'b0, 1'b0, 1'b0);
    wait_n(10);
    chk_st(7'b0000110);
    chk_code(12'h3c0);
  endtask
  // Wait of w ms is 4 * w cycles; no fault before it, fault soon after
  task automatic t_notravel(input logic [15:0] w);
    @(posedge clock);
    wait_t <= w;
    rst;
    set(1'b0, 1'b1, 1'b1);
    wait_n(6 + 4 * w);
    chk_st(7'b1111000);
    chk_code(12'h000);
    wait_n(8);
    chk_st(7'b1111001);
    chk_code(12'h216);
    set(1'b0, 1'b0, 1'b0);
    wait_n(10);
    chk_st(7'b0010100);
    chk_code(12'h000);
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    stop_test;
  end
  initial begin
    rst;
    t_travel;
    t_skew;
    t_lone(1'b1, 1'b0);
    t_lone(1'b0, 1'b1);
    t_notravel(16'h0003);
    t_notravel(16'h0005);
    stop_test;
  end
endmodule // testbench

//--- test/tom_relay_ctrl.sv
// Purpose: Elevator controller model driving the two relay channels
// Assumes: Bench asks for travel or bridges one or both relay contacts
// Notes:   No contact bounce modelled
module tom_relay_ctrl (
  input  wire logic clock,
  input  wire logic travel_req,
  input  wire logic bridge_a,
  input  wire logic bridge_b,
  output logic      travel_cmd = 1'b0,
  output logic      torque_enable_chan_a = 1'b0,
  output logic      torque_enable_chan_b = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // A bridged contact closes one channel alone, the fault being provoked
  always @(posedge clock) begin
    travel_cmd           <= travel_req;
    torque_enable_chan_a <= travel_req | bridge_a;
    torque_enable_chan_b <= travel_req | bridge_b;
  end
endmodule // tom_relay_ctrl
